/* dfl_pkg.sv */
// Constants and carriers shared by the DDR maintenance and calibration block.
package dfl_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_FLUSH_CTRL  = 8'h40;
    localparam logic [7:0] OFS_FLUSH_STAT  = 8'h44;
    localparam logic [7:0] OFS_SPLIT_CTRL  = 8'h48;
    localparam logic [7:0] OFS_CAL_UPDATE  = 8'h4C;
    localparam logic [7:0] OFS_PHY_DRIVE   = 8'h5C;
    localparam logic [7:0] OFS_WL_CTRL     = 8'h60;
    localparam logic [7:0] OFS_WL_DELAY    = 8'h68;
    localparam logic [7:0] OFS_DLY_SELECT  = 8'h6C;
    localparam logic [7:0] OFS_RL_CTRL     = 8'h70;
    localparam logic [7:0] OFS_RD_WINDOW   = 8'h74;
    localparam logic [7:0] OFS_WR_DLY_VAL  = 8'h78;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int FLUSH_EN_LSB   = 0;
    localparam int FLUSH_IE_LSB   = 8;
    localparam int DEBUG_IE_BIT   = 16;
    localparam int DEBUG_HIT_BIT  = 8;
    localparam int PROT_OVR_LSB   = 10;
    localparam int SPLIT_OFF_BIT  = 1;
    localparam int ZQ_MODE_LSB    = 16;
    localparam int WL_IVL_LSB     = 8;
    localparam int DLL_IVL_LSB    = 0;
    localparam int LVL_OK_LSB     = 24;
    localparam int WL_SW_LSB      = 16;
    localparam int RL_SW_LSB      = 0;
    localparam int WL_DLY_B1_LSB  = 8;
    localparam int RD_WIN_B1_LSB  = 4;
    localparam int WDLY_AMT_B1_LSB = 4;
    localparam int WR_PICK_B0_BIT = 1;
    localparam int WR_PICK_B1_BIT = 5;
    localparam int RD_PICK_B0_BIT = 0;
    localparam int RD_PICK_B1_BIT = 4;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] PROT_FORCE_BUF   = 2'h1;
    localparam logic [1:0] PROT_FORCE_NOBUF = 2'h2;
    localparam logic [1:0] ZQ_SHORT         = 2'h1;
    localparam logic [1:0] ZQ_LONG          = 2'h2;
    localparam logic [2:0] DRIVE_RESET      = 3'h7;
    localparam logic [7:0] WLO_RESET        = 8'h0A;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int INTERVAL_UNIT  = 1024;
    localparam int TXS_EXTRA_NS   = 10;
    localparam int TXS_EXTRA_CYC  =
        (TXS_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dfl_bus_t;

    typedef struct packed {
        logic       done;
        logic       ok;
        logic [6:0] value;
    } dfl_scan_t;

endpackage

/* dfl_ctrl.sv */
// Flush, calibration timing and leveling control block of the DDR controller.
`timescale 1ns/1ns
// What this block does
// - Writing one starts channel command flush.
// - Finished flush clears its enable bit.
// - Finished flush sets channel done status.
// - Status bits clear on write one.
// - Flush interrupt gated by per-channel enable.
// - Debug hit interrupt gated by enable.
// - Channel 1 bufferable override, else HPROT.
// - Split-off bit stops channel 1 SPLIT.
// - Self-refresh exit issues ZQCS or ZQCL.
// - ZQ command waits for tXS first.
// - Write-leveling repeats every N*1024 cycles.
// - DLL update repeats every N*1024 cycles.
// - Three-bit drive impedance, default 34 ohm.
// - Write-leveling software or hardware per byte.
// - Write-leveling pass flags read only.
// - Write DLL delay shows hardware or software.
// - Read-leveling software or hardware per byte.
// - Read window shows hardware or software.
// - Write select delays DQS or DQ.
// - Read select delays DQS or DQ.
// - Write delay amount per byte.
module dfl_ctrl
    import dfl_pkg::*;
#(
    parameter int TRFC_CYC = 11
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Register port
    input  wire dfl_bus_t    bus,
    output logic [31:0]      rdata,
    // Flush engine
    input  wire logic [3:0]  flush_finished,
    output logic [3:0]       flush_start,
    input  wire logic        debug_match,
    output logic             flush_irq,
    output logic             debug_irq,
    // Channel 1 bus attributes
    input  wire logic        ch1_hprot_buf,
    output logic             ch1_bufferable,
    output logic             ch1_split_off,
    // Self-refresh and periodic maintenance
    input  wire logic        sr_exit,
    output logic             zq_short_cmd,
    output logic             zq_long_cmd,
    output logic             wl_cal_req,
    output logic             dll_update_req,
    // PHY settings
    output logic [2:0]       drive_impedance_select,
    output logic [7:0]       dqs_to_dq_latch_delay,
    output logic [1:0]       wl_hw_scan_en,
    output logic [1:0]       rl_hw_scan_en,
    output logic [13:0]      wr_dll_delay,
    output logic [7:0]       rd_filter_window,
    output logic [1:0]       wr_strobe_delay_pick,
    output logic [1:0]       rd_strobe_delay_pick,
    output logic [5:0]       wr_delay_amount,
    // Scan results per byte
    input  wire dfl_scan_t   wl_scan_b0,
    input  wire dfl_scan_t   wl_scan_b1,
    input  wire dfl_scan_t   rl_scan_b0,
    input  wire dfl_scan_t   rl_scan_b1
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ZQ_IDLE, ZQ_WAIT, ZQ_FIRE} dfl_zq_t;

    localparam int TXS_CYC = TRFC_CYC + TXS_EXTRA_CYC;
    localparam int IVL_W   = 18;

    logic [3:0]  flush_en_reg, flush_en_next;
    logic [3:0]  flush_ie_reg, flush_ie_next;
    logic        debug_ie_reg, debug_ie_next;
    logic [3:0]  done_reg, done_next;
    logic        hit_reg, hit_next;
    logic [1:0]  prot_reg, prot_next;
    logic        split_reg, split_next;
    logic [1:0]  zqm_reg, zqm_next;
    logic [7:0]  wl_ivl_reg, wl_ivl_next;
    logic [7:0]  dll_ivl_reg, dll_ivl_next;
    logic [2:0]  drive_reg, drive_next;
    logic [1:0]  wl_sw_reg, wl_sw_next;
    logic [7:0]  wlo_reg, wlo_next;
    logic [1:0]  wl_ok_reg, wl_ok_next;
    logic [13:0] wl_dly_reg, wl_dly_next;
    logic [3:0]  pick_reg, pick_next;
    logic [1:0]  rl_sw_reg, rl_sw_next;
    logic [1:0]  rl_ok_reg, rl_ok_next;
    logic [7:0]  rwin_reg, rwin_next;
    logic [5:0]  wamt_reg, wamt_next;
    logic [31:0] rdata_next;
    dfl_zq_t     zq_reg, zq_next;
    logic [7:0]  txs_reg, txs_next;
    logic        zqs_reg, zqs_next, zql_reg, zql_next;
    logic [IVL_W-1:0] wl_cnt_reg, wl_cnt_next, dll_cnt_reg, dll_cnt_next;
    logic        wl_req_reg, wl_req_next, dll_req_reg, dll_req_next;
    logic        fin_irq_reg, fin_irq_next, dbg_irq_reg, dbg_irq_next;
    logic        buf_reg, buf_next;

    // Interval counter step: reload at N*1024, pulse on reaching one.
    function automatic logic [IVL_W:0] ivl_step(logic [7:0] n,
                                                logic [IVL_W-1:0] c);
        logic [IVL_W-1:0] span;
        span = IVL_W'({n, 10'h000});
        if (n == 8'h00) begin
            ivl_step = '0;
        end else if (c <= IVL_W'(1)) begin
            ivl_step = {1'b1, span};
        end else begin
            ivl_step = {1'b0, c - IVL_W'(1)};
        end
    endfunction

    // ------------------------------------------------------------------
    // Register writes and hardware updates
    // ------------------------------------------------------------------
    always_comb begin
        logic wr_hit;
        logic [31:0] d;
        wr_hit        = bus.wr;
        d             = bus.wdata;
        flush_en_next = flush_en_reg & ~flush_finished;
        flush_ie_next = flush_ie_reg;
        debug_ie_next = debug_ie_reg;
        done_next     = done_reg;
        hit_next      = hit_reg;
        prot_next     = prot_reg;
        split_next    = split_reg;
        zqm_next      = zqm_reg;
        wl_ivl_next   = wl_ivl_reg;
        dll_ivl_next  = dll_ivl_reg;
        drive_next    = drive_reg;
        wl_sw_next    = wl_sw_reg;
        wlo_next      = wlo_reg;
        wl_ok_next    = wl_ok_reg;
        wl_dly_next   = wl_dly_reg;
        pick_next     = pick_reg;
        rl_sw_next    = rl_sw_reg;
        rl_ok_next    = rl_ok_reg;
        rwin_next     = rwin_reg;
        wamt_next     = wamt_reg;
        if (wr_hit) begin
            unique case (bus.addr)
                OFS_FLUSH_CTRL: begin
                    flush_en_next = flush_en_next
                        | d[FLUSH_EN_LSB +: 4];
                    flush_ie_next = d[FLUSH_IE_LSB +: 4];
                    debug_ie_next = d[DEBUG_IE_BIT];
                end
                OFS_FLUSH_STAT: begin
                    done_next = done_reg & ~d[3:0];
                    hit_next  = hit_reg & ~d[DEBUG_HIT_BIT];
                end
                OFS_SPLIT_CTRL: begin
                    prot_next  = d[PROT_OVR_LSB +: 2];
                    split_next = d[SPLIT_OFF_BIT];
                end
                OFS_CAL_UPDATE: begin
                    zqm_next     = d[ZQ_MODE_LSB +: 2];
                    wl_ivl_next  = d[WL_IVL_LSB +: 8];
                    dll_ivl_next = d[DLL_IVL_LSB +: 8];
                end
                OFS_PHY_DRIVE:  drive_next = d[2:0];
                OFS_WL_CTRL: begin
                    wl_sw_next = d[WL_SW_LSB +: 2];
                    wlo_next   = d[7:0];
                end
                OFS_WL_DELAY: begin
                    if (wl_sw_reg[0]) wl_dly_next[6:0] = d[6:0];
                    if (wl_sw_reg[1]) begin
                        wl_dly_next[13:7] = d[WL_DLY_B1_LSB +: 7];
                    end
                end
                OFS_DLY_SELECT: begin
                    pick_next = {d[WR_PICK_B1_BIT], d[RD_PICK_B1_BIT],
                                 d[WR_PICK_B0_BIT], d[RD_PICK_B0_BIT]};
                end
                OFS_RL_CTRL:    rl_sw_next = d[RL_SW_LSB +: 2];
                OFS_RD_WINDOW: begin
                    if (rl_sw_reg[0]) rwin_next[3:0] = d[3:0];
                    if (rl_sw_reg[1]) begin
                        rwin_next[7:4] = d[RD_WIN_B1_LSB +: 4];
                    end
                end
                OFS_WR_DLY_VAL: begin
                    wamt_next = {d[WDLY_AMT_B1_LSB +: 3], d[2:0]};
                end
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle software clear.
        done_next = done_next | (flush_en_reg & flush_finished);
        hit_next  = hit_next | debug_match;
        // Scan results land only on completion and only in hardware mode.
        if (wl_sw_next[0]) wl_ok_next[0] = 1'b0;
        else if (wl_scan_b0.done) begin
            wl_ok_next[0]    = wl_scan_b0.ok;
            wl_dly_next[6:0] = wl_scan_b0.value;
        end
        if (wl_sw_next[1]) wl_ok_next[1] = 1'b0;
        else if (wl_scan_b1.done) begin
            wl_ok_next[1]     = wl_scan_b1.ok;
            wl_dly_next[13:7] = wl_scan_b1.value;
        end
        if (rl_sw_next[0]) rl_ok_next[0] = 1'b0;
        else if (rl_scan_b0.done) begin
            rl_ok_next[0]  = rl_scan_b0.ok;
            rwin_next[3:0] = rl_scan_b0.value[3:0];
        end
        if (rl_sw_next[1]) rl_ok_next[1] = 1'b0;
        else if (rl_scan_b1.done) begin
            rl_ok_next[1]  = rl_scan_b1.ok;
            rwin_next[7:4] = rl_scan_b1.value[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Read data, outputs, ZQ sequencing and intervals
    // ------------------------------------------------------------------
    always_comb begin
        logic [IVL_W:0] ws, ds;
        ws = ivl_step(wl_ivl_reg, wl_cnt_reg);
        ds = ivl_step(dll_ivl_reg, dll_cnt_reg);
        rdata_next = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_FLUSH_CTRL: rdata_next = {15'h0000, debug_ie_reg,
                    4'h0, flush_ie_reg, 4'h0, flush_en_reg};
                OFS_FLUSH_STAT: rdata_next = {23'h000000, hit_reg,
                    4'h0, done_reg};
                OFS_SPLIT_CTRL: rdata_next = {20'h00000, prot_reg,
                    8'h00, split_reg, 1'b0};
                OFS_CAL_UPDATE: rdata_next = {14'h0000, zqm_reg,
                    wl_ivl_reg, dll_ivl_reg};
                OFS_PHY_DRIVE:  rdata_next = {29'h00000000, drive_reg};
                OFS_WL_CTRL:    rdata_next = {6'h00, wl_ok_reg, 6'h00,
                    wl_sw_reg, 8'h00, wlo_reg};
                OFS_WL_DELAY:   rdata_next = {17'h00000, wl_dly_reg[13:7],
                    1'b0, wl_dly_reg[6:0]};
                OFS_DLY_SELECT: rdata_next = {26'h0000000, pick_reg[3:2],
                    2'h0, pick_reg[1:0]};
                OFS_RL_CTRL:    rdata_next = {6'h00, rl_ok_reg, 22'h000000,
                    rl_sw_reg};
                OFS_RD_WINDOW:  rdata_next = {24'h000000, rwin_reg};
                OFS_WR_DLY_VAL: rdata_next = {25'h0000000, wamt_reg[5:3],
                    1'b0, wamt_reg[2:0]};
                default:        rdata_next = '0;
            endcase
        end
        fin_irq_next = |(done_reg & flush_ie_reg);
        dbg_irq_next = hit_reg & debug_ie_reg;
        unique case (prot_reg)
            PROT_FORCE_BUF:   buf_next = 1'b1;
            PROT_FORCE_NOBUF: buf_next = 1'b0;
            default:          buf_next = ch1_hprot_buf;
        endcase
        zq_next  = zq_reg;
        txs_next = txs_reg;
        zqs_next = 1'b0;
        zql_next = 1'b0;
        unique case (zq_reg)
            ZQ_IDLE: if (sr_exit && (zqm_reg == ZQ_SHORT
                                     || zqm_reg == ZQ_LONG)) begin
                zq_next  = ZQ_WAIT;
                txs_next = 8'(TXS_CYC - 1);
            end
            ZQ_WAIT: if (txs_reg == 8'h00) begin
                zq_next = ZQ_FIRE;
            end else begin
                txs_next = txs_reg - 8'h01;
            end
            ZQ_FIRE: begin
                zq_next  = ZQ_IDLE;
                zqs_next = (zqm_reg == ZQ_SHORT);
                zql_next = (zqm_reg == ZQ_LONG);
            end
        endcase
        wl_req_next  = ws[IVL_W];
        wl_cnt_next  = ws[IVL_W-1:0];
        dll_req_next = ds[IVL_W];
        dll_cnt_next = ds[IVL_W-1:0];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flush_en_reg <= '0;
            flush_ie_reg <= '0;
            debug_ie_reg <= 1'b0;
            done_reg     <= '0;
            hit_reg      <= 1'b0;
            prot_reg     <= '0;
            split_reg    <= 1'b0;
            zqm_reg      <= '0;
            wl_ivl_reg   <= '0;
            dll_ivl_reg  <= '0;
            drive_reg    <= DRIVE_RESET;
            wl_sw_reg    <= '0;
            wlo_reg      <= WLO_RESET;
            wl_ok_reg    <= '0;
            wl_dly_reg   <= '0;
            pick_reg     <= '0;
            rl_sw_reg    <= '0;
            rl_ok_reg    <= '0;
            rwin_reg     <= '0;
            wamt_reg     <= '0;
            rdata        <= '0;
            zq_reg       <= ZQ_IDLE;
            txs_reg      <= '0;
            zqs_reg      <= 1'b0;
            zql_reg      <= 1'b0;
            wl_cnt_reg   <= '0;
            dll_cnt_reg  <= '0;
            wl_req_reg   <= 1'b0;
            dll_req_reg  <= 1'b0;
            fin_irq_reg  <= 1'b0;
            dbg_irq_reg  <= 1'b0;
            buf_reg      <= 1'b0;
        end else begin
            flush_en_reg <= flush_en_next;
            flush_ie_reg <= flush_ie_next;
            debug_ie_reg <= debug_ie_next;
            done_reg     <= done_next;
            hit_reg      <= hit_next;
            prot_reg     <= prot_next;
            split_reg    <= split_next;
            zqm_reg      <= zqm_next;
            wl_ivl_reg   <= wl_ivl_next;
            dll_ivl_reg  <= dll_ivl_next;
            drive_reg    <= drive_next;
            wl_sw_reg    <= wl_sw_next;
            wlo_reg      <= wlo_next;
            wl_ok_reg    <= wl_ok_next;
            wl_dly_reg   <= wl_dly_next;
            pick_reg     <= pick_next;
            rl_sw_reg    <= rl_sw_next;
            rl_ok_reg    <= rl_ok_next;
            rwin_reg     <= rwin_next;
            wamt_reg     <= wamt_next;
            rdata        <= rdata_next;
            zq_reg       <= zq_next;
            txs_reg      <= txs_next;
            zqs_reg      <= zqs_next;
            zql_reg      <= zql_next;
            wl_cnt_reg   <= wl_cnt_next;
            dll_cnt_reg  <= dll_cnt_next;
            wl_req_reg   <= wl_req_next;
            dll_req_reg  <= dll_req_next;
            fin_irq_reg  <= fin_irq_next;
            dbg_irq_reg  <= dbg_irq_next;
            buf_reg      <= buf_next;
        end
    end

    // The pick and amount bits go straight to the PHY delay lines.
    assign flush_start            = flush_en_reg;
    assign flush_irq              = fin_irq_reg;
    assign debug_irq              = dbg_irq_reg;
    assign ch1_bufferable         = buf_reg;
    assign ch1_split_off          = split_reg;
    assign zq_short_cmd           = zqs_reg;
    assign zq_long_cmd            = zql_reg;
    assign wl_cal_req             = wl_req_reg;
    assign dll_update_req         = dll_req_reg;
    assign drive_impedance_select = drive_reg;
    assign dqs_to_dq_latch_delay  = wlo_reg;
    assign wl_hw_scan_en          = ~wl_sw_reg;
    assign rl_hw_scan_en          = ~rl_sw_reg;
    assign wr_dll_delay           = wl_dly_reg;
    assign rd_filter_window       = rwin_reg;
    assign wr_strobe_delay_pick   = {pick_reg[3], pick_reg[1]};
    assign rd_strobe_delay_pick   = {pick_reg[2], pick_reg[0]};
    assign wr_delay_amount        = wamt_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_fin(int c);
        flush_en_reg[0] && flush_finished[0];
    endsequence

    a_flush_self_clear: assert property (s_fin(0) |=> !flush_en_reg[0])
        else $error("flush enable not cleared");
    a_flush_done_set: assert property (s_fin(0) |=> done_reg[0])
        else $error("flush done not set");
    a_flush_irq_lvl: assert property (
        (done_reg[0] && flush_ie_reg[0]) |=> flush_irq)
        else $error("flush interrupt missing");
    a_debug_irq_gate: assert property (
        !debug_ie_reg |=> !debug_irq)
        else $error("debug interrupt not gated");
    a_prot_force: assert property (
        prot_reg == PROT_FORCE_BUF |=> ch1_bufferable)
        else $error("bufferable override ignored");
    a_zq_after_txs: assert property (
        (zq_reg == ZQ_IDLE && sr_exit && zqm_reg == ZQ_SHORT
         && !(bus.wr && bus.addr == OFS_CAL_UPDATE))
        |-> !zq_short_cmd [*3] ##[1:300] zq_short_cmd)
        else $error("ZQCS not issued after tXS");
    a_wl_ok_sw: assert property (wl_sw_reg[0] |-> !wl_ok_reg[0])
        else $error("pass flag set in software mode");
    a_rl_hold: assert property (
        (!rl_scan_b0.done && !(bus.wr && bus.addr == OFS_RD_WINDOW)
         && !rl_sw_reg[0]) |=> $stable(rwin_reg[3:0]))
        else $error("read window changed without scan");

endmodule // dfl_ctrl

/* dfl_phy_model.sv */
// Behavioural flush engine and leveling scanner facing the block.
`timescale 1ns/1ns
module dfl_phy_model
    import dfl_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Flush engine side
    input  wire logic [3:0] flush_start,
    output logic [3:0]      flush_finished,
    // Scanner side
    input  wire logic       scan_go,
    input  wire logic [6:0] scan_val,
    output dfl_scan_t       scan
);
    // Channel i needs 4 + i cycles, so channels finish out of step.
    logic [3:0] age [4] = '{default: 4'h0};
    initial flush_finished = 4'h0;
    initial scan = '0;
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            age[i] <= flush_start[i] ? age[i] + 4'h1 : 4'h0;
            flush_finished[i] <= flush_start[i] && age[i] == 4'(3 + i);
        end
        // Outside a done pulse the value toggles so stale data never pass.
        scan <= '{scan_go, scan_go, scan_go ? scan_val : ~scan.value};
    end
endmodule // dfl_phy_model

/* tb_top.sv */
// Self-checking testbench for the DDR flush and leveling control block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top
    import dfl_pkg::*;
;
    localparam int TRFC = 2;
    int          n_fail = 0;
    int          compares = 0;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    dfl_bus_t    bus = '0;
    dfl_scan_t   scan;
    logic [31:0] rdata;
    logic [13:0] wr_dll_delay;
    logic [7:0]  rd_filter_window, dqs_to_dq_latch_delay;
    logic [5:0]  wr_delay_amount;
    logic [3:0]  flush_finished, flush_start;
    logic [2:0]  drive_impedance_select;
    logic [1:0]  wl_hw_scan_en, rl_hw_scan_en;
    logic [1:0]  wr_strobe_delay_pick, rd_strobe_delay_pick;
    logic        debug_match = 1'b0;
    logic        ch1_hprot_buf = 1'b0;
    logic        sr_exit = 1'b0;
    logic        scan_go = 1'b0;
    logic [6:0]  scan_val = 7'h35;
    logic        flush_irq, debug_irq, ch1_bufferable, ch1_split_off;
    logic        zq_short_cmd, zq_long_cmd, wl_cal_req, dll_update_req;

    dfl_ctrl #(.TRFC_CYC(TRFC)) u_dfl_ctrl (
        .clk, .arst_n, .bus, .rdata, .flush_finished, .flush_start,
        .debug_match, .flush_irq, .debug_irq, .ch1_hprot_buf,
        .ch1_bufferable, .ch1_split_off, .sr_exit, .zq_short_cmd,
        .zq_long_cmd, .wl_cal_req, .dll_update_req,
        .drive_impedance_select, .dqs_to_dq_latch_delay, .wl_hw_scan_en,
        .rl_hw_scan_en, .wr_dll_delay, .rd_filter_window,
        .wr_strobe_delay_pick, .rd_strobe_delay_pick, .wr_delay_amount,
        .wl_scan_b0(scan), .wl_scan_b1(scan), .rl_scan_b0(scan),
        .rl_scan_b1(scan)
    );
    dfl_phy_model u_dfl_phy_model (
        .clk, .flush_start, .flush_finished, .scan_go, .scan_val, .scan
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        `CHK("rdata", e, rdata)
    endtask
    task automatic scan_pulse();
        @(posedge clk);
        scan_go <= 1'b1;
        @(posedge clk);
        scan_go <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_regs();
        @(negedge clk);
        `CHK("wlo", 8'h0A, dqs_to_dq_latch_delay)
        `CHK("wl_hw", 2'h3, wl_hw_scan_en)
        `CHK("rl_hw", 2'h3, rl_hw_scan_en)
        @(posedge clk);
        debug_match <= 1'b1;
        @(posedge clk);
        debug_match <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("dirq_off", 1'b0, debug_irq)
        rd(OFS_WL_CTRL, 32'h0000000A);
        wr(8'h50, 32'hFFFFFFFF);
        rd(8'h50, 32'h0);
        for (int v = 7; v >= 0; v--) begin
            rd(OFS_PHY_DRIVE, 32'(v));
            `CHK("drive", 3'(v), drive_impedance_select)
            wr(OFS_PHY_DRIVE, 32'(v - 1));
        end
    endtask
    task automatic t_flush();
        wr(OFS_FLUSH_CTRL, 32'h0001030F);
        @(negedge clk);
        `CHK("start", 4'hF, flush_start)
        repeat (30) begin
            if (flush_start !== 4'h0) @(negedge clk);
        end
        @(posedge clk);
        debug_match <= 1'b1;
        @(posedge clk);
        debug_match <= 1'b0;
        rd(OFS_FLUSH_CTRL, 32'h00010300);
        rd(OFS_FLUSH_STAT, 32'h0000010F);
        `CHK("firq", 1'b1, flush_irq)
        `CHK("dirq", 1'b1, debug_irq)
        wr(OFS_FLUSH_STAT, 32'h0);
        rd(OFS_FLUSH_STAT, 32'h0000010F);
        wr(OFS_FLUSH_STAT, 32'h00000103);
        repeat (2) @(negedge clk);
        `CHK("firq", 1'b0, flush_irq)
        `CHK("dirq", 1'b0, debug_irq)
        rd(OFS_FLUSH_STAT, 32'h0000000C);
    endtask
    task automatic t_bus();
        for (int s = 0; s < 4; s++) begin
            for (int h = 0; h < 2; h++) begin
                wr(OFS_SPLIT_CTRL, 32'(s << 10 | h << 1));
                ch1_hprot_buf <= h[0];
                repeat (2) @(negedge clk);
                `CHK("buf", s == 1 || (s != 2 && h == 1), ch1_bufferable)
                `CHK("split", h[0], ch1_split_off)
            end
        end
    endtask
    task automatic t_zq();
        int n, ns, nl;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CAL_UPDATE, 32'(m) << 16);
            @(posedge clk);
            sr_exit <= 1'b1;
            @(posedge clk);
            sr_exit <= 1'b0;
            ns = 0;
            nl = 0;
            n = 0;
            for (int c = 0; c < 3 * TRFC + 10; c++) begin
                @(negedge clk);
                if (zq_short_cmd !== 1'b0) ns++;
                if (zq_long_cmd !== 1'b0) nl++;
                if ((zq_short_cmd | zq_long_cmd) !== 1'b0) n = c;
            end
            `CHK("zqs", 32'(m == 1), ns)
            `CHK("zql", 32'(m == 2), nl)
            if (m == 1 || m == 2) `CHK("zq_at", TRFC + 2, n)
        end
    endtask
    task automatic t_level();
        scan_pulse();
        `CHK("wdll", 14'h1AB5, wr_dll_delay)
        `CHK("rwin", 8'h55, rd_filter_window)
        rd(OFS_WL_CTRL, 32'h0300000A);
        rd(OFS_RL_CTRL, 32'h03000000);
        // Write-leveling pass bits are written high here, but software mode on both bytes clears them anyway.
        wr(OFS_WL_CTRL, 32'h0303000A);
        wr(OFS_RL_CTRL, 32'h00000003);
        wr(OFS_WL_DELAY, 32'h00001234);
        wr(OFS_RD_WINDOW, 32'h000000A6);
        scan_pulse();
        rd(OFS_WL_CTRL, 32'h0003000A);
        rd(OFS_RL_CTRL, 32'h00000003);
        rd(OFS_WL_DELAY, 32'h00001234);
        rd(OFS_RD_WINDOW, 32'h000000A6);
        `CHK("wl_hw", 2'h0, wl_hw_scan_en)
        wr(OFS_DLY_SELECT, 32'h00000022);
        wr(OFS_WR_DLY_VAL, 32'h00000053);
        rd(OFS_WR_DLY_VAL, 32'h00000053);
        `CHK("wpick", 2'h3, wr_strobe_delay_pick)
        `CHK("rpick", 2'h0, rd_strobe_delay_pick)
        `CHK("wamt", 6'h2B, wr_delay_amount)
        wr(OFS_DLY_SELECT, 32'h00000011);
        rd(OFS_DLY_SELECT, 32'h00000011);
        `CHK("rpick", 2'h3, rd_strobe_delay_pick)
    endtask
    task automatic t_ivl();
        int a = -1;
        int b = -1;
        int pa = 0;
        int pb = 0;
        int q = 0;
        wr(OFS_CAL_UPDATE, 32'h00000102);
        for (int c = 0; c < 4400; c++) begin
            @(negedge clk);
            if (wl_cal_req === 1'b1) begin
                if (a >= 0) pa = c - a;
                a = c;
            end
            if (dll_update_req === 1'b1) begin
                if (b >= 0) pb = c - b;
                b = c;
            end
        end
        `CHK("wl_per", 1024, pa)
        `CHK("dll_per", 2048, pb)
        wr(OFS_CAL_UPDATE, 32'h0);
        for (int c = 0; c < 2100; c++) begin
            @(negedge clk);
            if ((wl_cal_req | dll_update_req) !== 1'b0) q++;
        end
        `CHK("ivl_off", 0, q)
    endtask
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial forever #50 clk = ~clk;
    // The run needs about 7000 cycles; the watchdog allows nearly three times.
    initial begin
        #2000000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_flush();
        t_bus();
        t_zq();
        t_level();
        t_ivl();
        finish_test();
    end
endmodule // tb_top
